// [shared/mic_pkg.sv]
// Purpose: Constants for the mode and serial-bus control register pair.
// Assumes: 125 MHz core clock; register port driven by the serial slave.
// Notes:   Times are kept in their own units; cycle counts are derived.
package mic_pkg;
  localparam int          CLK_MHZ         = 125;
  // Register offsets on the serial control bus.
  localparam logic [7:0]  MODE_ADDR       = 8'h04;
  localparam logic [7:0]  CTRL_ADDR       = 8'h05;
  localparam logic [7:0]  MODE_RESET      = 8'h80;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  // Writable bits; the rest are reserved and read as zero.
  localparam logic [7:0]  MODE_WMASK      = 8'haf;
  localparam logic [7:0]  CTRL_WMASK      = 8'h1f;
  // Mode register fields.
  localparam int          FAILSAFE_BIT    = 7;
  localparam int          CRC_CLR_BIT     = 5;
  localparam int          LEG_OVR_BIT     = 3;
  localparam int          LEG_MODE_BIT    = 2;
  localparam int          FRQ_OVR_BIT     = 1;
  localparam int          FRQ_MODE_BIT    = 0;
  // Serial-bus control fields.
  localparam int          SDA_DLY_LO      = 3;
  localparam int          SDA_DLY_HI      = 4;
  localparam int          RWR_BLOCK_BIT   = 2;
  localparam int          WD_FAST_BIT     = 1;
  localparam int          WD_OFF_BIT      = 0;
  // SDA output delay: base plus steps, rounded up to whole cycles.
  localparam int          SDA_BASE_NS     = 240;
  localparam int          SDA_STEP_NS     = 40;
  localparam int          SDA_BASE_CYC    = (SDA_BASE_NS * CLK_MHZ + 999) / 1000;
  localparam int          SDA_STEP_CYC    = (SDA_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int          SDA_LINE_DEPTH  = SDA_BASE_CYC + 3 * SDA_STEP_CYC;
  // Watchdog timeouts (longest times, rounded down).
  localparam int          WD_SLOW_US      = 1000000;
  localparam int          WD_FAST_US      = 50;
  localparam int          WD_SLOW_CYC     = WD_SLOW_US * CLK_MHZ;
  localparam int          WD_FAST_CYC     = WD_FAST_US * CLK_MHZ;
  // Bus recovery clock: half period and pulse count.
  localparam int          RECOV_HALF_NS   = 5000;
  localparam int          RECOV_HALF_CYC  = (RECOV_HALF_NS * CLK_MHZ) / 1000;
  localparam logic [3:0]  RECOV_PULSES    = 4'h9;
  typedef enum logic {MIC_WD_WATCH, MIC_WD_RECOVER} mic_wd_state_t;
endpackage

// [shared/mic_wdog_if.sv]
// Purpose: Carries watchdog configuration and status between top and watchdog.
// Assumes: Single clock domain.
// Notes:   The top drives configuration; the watchdog reports state.
`timescale 1ns/1ns
`default_nettype none
interface mic_wdog_if;
  logic enable;
  logic speedup;
  logic bus_free;
  logic recovering;
  modport ctrl (output enable, output speedup, input bus_free, input recovering);
  modport wdog (input enable, input speedup, output bus_free, output recovering);
endinterface
`default_nettype wire

// [hw/mic_bus_wdog.sv]
// Purpose: Serial bus watchdog that detects a free bus or clears a hung one.
// Assumes: scl_in and sda_in are synchronous to clk.
// Notes:   SCL is open drain; the pin is pulled low only while scl_oe is high.
`timescale 1ns/1ns
`default_nettype none
module mic_bus_wdog
  import mic_pkg::*;
#(
  parameter int SLOW_CYC = WD_SLOW_CYC,
  parameter int FAST_CYC = WD_FAST_CYC,
  parameter int HALF_CYC = RECOV_HALF_CYC
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       scl_out,
  output logic       scl_oe,
  mic_wdog_if.wdog   cfg
);
  mic_wd_state_t state_ff;
  logic [31:0]   idle_cnt_ff;
  logic [31:0]   half_cnt_ff;
  logic [3:0]    pulse_cnt_ff;
  logic          scl_prev_ff;
  logic          sda_prev_ff;
  logic          scl_oe_ff;
  logic          bus_free_ff;
  logic          activity;
  logic [31:0]   limit;
  logic          half_done;

  // Any edge on either line counts as bus activity and restarts the idle count.
  assign activity  = (scl_in != scl_prev_ff) || (sda_in != sda_prev_ff);
  assign limit     = cfg.speedup ? 32'(FAST_CYC) : 32'(SLOW_CYC); // RL10
  assign half_done = (half_cnt_ff == 32'(HALF_CYC - 1));
  assign scl_out   = 1'b0;
  assign scl_oe    = scl_oe_ff;
  assign cfg.bus_free   = bus_free_ff;
  assign cfg.recovering = (state_ff == MIC_WD_RECOVER);

  // Line history for the activity detector.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_in;
      sda_prev_ff <= sda_in;
    end
  end

  // Idle timing, free-bus report and nine-pulse recovery sequence.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= MIC_WD_WATCH;
      idle_cnt_ff  <= 32'h0;
      half_cnt_ff  <= 32'h0;
      pulse_cnt_ff <= 4'h0;
      scl_oe_ff    <= 1'b0;
      bus_free_ff  <= 1'b0;
    end else begin
      bus_free_ff <= 1'b0;
      unique case (state_ff)
        MIC_WD_WATCH: begin
          if (!cfg.enable || activity) begin // RL13
            idle_cnt_ff <= 32'h0;
          end else if (idle_cnt_ff >= limit - 32'h1) begin
            idle_cnt_ff <= 32'h0;
            if (sda_in) begin
              bus_free_ff <= 1'b1; // RL11
            end else begin
              state_ff     <= MIC_WD_RECOVER; // RL12
              half_cnt_ff  <= 32'h0;
              pulse_cnt_ff <= 4'h0;
              scl_oe_ff    <= 1'b1;
            end
          end else begin
            idle_cnt_ff <= idle_cnt_ff + 32'h1;
          end
        end
        MIC_WD_RECOVER: begin
          if (!cfg.enable) begin // RL13
            state_ff  <= MIC_WD_WATCH;
            scl_oe_ff <= 1'b0;
          end else if (half_done) begin
            half_cnt_ff <= 32'h0;
            scl_oe_ff   <= ~scl_oe_ff;
            // Each release of SCL ends one clock pulse.
            if (scl_oe_ff) begin
              pulse_cnt_ff <= pulse_cnt_ff + 4'h1; // RL12
              if (pulse_cnt_ff == RECOV_PULSES - 4'h1) begin
                state_ff <= MIC_WD_WATCH;
              end
            end
          end else begin
            half_cnt_ff <= half_cnt_ff + 32'h1;
          end
        end
      endcase
    end
  end

  // The recovery never issues more than nine pulses.
  chk_pulse_limit: assert property (@(posedge clk) disable iff (!rst_n) // RL12
    pulse_cnt_ff <= RECOV_PULSES) else $error("Too many recovery pulses.");
  // A watchdog still disabled one cycle later no longer pulls SCL nor reports a free bus.
  chk_wdog_off: assert property (@(posedge clk) disable iff (!rst_n) // RL13
    !cfg.enable ##1 !cfg.enable |-> !scl_oe_ff && !bus_free_ff)
    else $error("Disabled watchdog acted on the bus.");
  // A free-bus report only follows a high SDA line.
  chk_free_high: assert property (@(posedge clk) disable iff (!rst_n) // RL11
    bus_free_ff |-> $past(sda_in) && $past(state_ff) == MIC_WD_WATCH)
    else $error("Free bus reported with SDA low.");
  // Recovery starts only from a low SDA line.
  chk_recov_low: assert property (@(posedge clk) disable iff (!rst_n) // RL12
    $rose(scl_oe_ff) && $past(state_ff) == MIC_WD_WATCH |-> !$past(sda_in))
    else $error("Recovery started with SDA high.");
  cov_bus_free: cover property (@(posedge clk) disable iff (!rst_n) bus_free_ff);
  cov_recover_done: cover property (@(posedge clk) disable iff (!rst_n)
    state_ff == MIC_WD_RECOVER ##1 state_ff == MIC_WD_WATCH);
endmodule
`default_nettype wire

// [hw/mic_ctrl_regs.sv]
// Purpose: Mode and serial-bus control registers of the serializer.
// Assumes: The serial slave presents decoded register accesses on reg_*.
// Notes:   reg_wr_remote marks a write that came across the control channel.
// What this block does
// RL1: Mode bit 7 picks failsafe level, 1 low; mode resets to 0x80.
// RL2: Setting mode bit 5 clears back-channel CRC error flags and counts.
// RL3: Override bit 3 picks legacy mode from strap pin or register bit.
// RL4: Bit 2 selects legacy pairing mode; 0 is normal protected operation.
// RL5: Override bit 1 picks frequency range from strap pin or register.
// RL6: Bit 0 selects pixel clock range; 0 high, 1 low.
// RL7: SDA delay field adds 40 ns steps to a 240 ns base.
// RL8: Control bit 2 refuses register writes from far-end masters.
// RL9: Remote access to local bus slaves stays open under the write block.
// RL10: Control bit 1 picks watchdog timeout, about 1 s or 50 us.
// RL11: SDA high and idle for the timeout means the bus is free.
// RL12: SDA low and idle for the timeout triggers nine SCL pulses.
// RL13: Control bit 0 set turns the bus watchdog off.
// RL14: Serial-bus control register resets to 0x00.
// RL15: Reserved bits read as zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
module mic_ctrl_regs
  import mic_pkg::*;
#(
  parameter int SLOW_CYC = WD_SLOW_CYC,
  parameter int FAST_CYC = WD_FAST_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic        reg_wr_remote,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        legacy_strap_pin,
  input  wire logic        freq_strap_pin,
  input  wire logic        sda_drive_req,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             failsafe_low,
  output logic             crc_err_clear,
  output logic             legacy_pair_mode,
  output logic             low_freq_range,
  output logic             remote_wr_refused,
  output logic             bus_free
);
  logic [7:0]                 mode_ff;
  logic [7:0]                 ctrl_ff;
  logic [7:0]                 rdata_ff;
  logic                       legacy_ff;
  logic                       freq_ff;
  logic                       refused_ff;
  logic [SDA_LINE_DEPTH-1:0]  sda_line_ff;
  logic                       sda_oe_ff;
  logic                       wr_allowed;
  logic [1:0]                 sda_code;
  logic [5:0]                 sda_tap;
  mic_wdog_if                 wd_if ();

  // Far-end writes are dropped when blocked; pass-through traffic is not seen here.
  assign wr_allowed = reg_wr_en && !(reg_wr_remote && ctrl_ff[RWR_BLOCK_BIT]); // RL8 RL9
  assign sda_code   = ctrl_ff[SDA_DLY_HI:SDA_DLY_LO];
  assign sda_tap    = 6'(SDA_BASE_CYC - 2) + 6'(sda_code) * 6'(SDA_STEP_CYC); // RL7

  // Register storage; reserved bits are masked away on every write.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= MODE_RESET; // RL1
      ctrl_ff <= CTRL_RESET; // RL14
    end else if (wr_allowed) begin
      if (reg_addr == MODE_ADDR) begin
        mode_ff <= reg_wdata & MODE_WMASK; // RL15
      end
      if (reg_addr == CTRL_ADDR) begin
        ctrl_ff <= reg_wdata & CTRL_WMASK; // RL15
      end
    end
  end

  // Read data; unmapped offsets read as zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_en) begin
      rdata_ff <= (reg_addr == MODE_ADDR) ? mode_ff :
                  (reg_addr == CTRL_ADDR) ? ctrl_ff : 8'h00;
    end
  end

  // Effective mode selections from strap pins or register bits.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      legacy_ff <= 1'b0;
      freq_ff   <= 1'b0;
    end else begin
      legacy_ff <= mode_ff[LEG_OVR_BIT] ? mode_ff[LEG_MODE_BIT] : legacy_strap_pin; // RL3 RL4
      freq_ff   <= mode_ff[FRQ_OVR_BIT] ? mode_ff[FRQ_MODE_BIT] : freq_strap_pin; // RL5 RL6
    end
  end

  // Pulse for each refused far-end register write.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_ff <= 1'b0;
    end else begin
      refused_ff <= reg_wr_en && !wr_allowed; // RL8
    end
  end

  // SDA output delay line, tapped by the programmed delay code.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_line_ff <= '0;
      sda_oe_ff   <= 1'b0;
    end else begin
      sda_line_ff <= {sda_line_ff[SDA_LINE_DEPTH-2:0], sda_drive_req};
      sda_oe_ff   <= sda_line_ff[sda_tap]; // RL7
    end
  end

  assign failsafe_low      = mode_ff[FAILSAFE_BIT]; // RL1
  assign crc_err_clear     = mode_ff[CRC_CLR_BIT]; // RL2
  assign legacy_pair_mode  = legacy_ff;
  assign low_freq_range    = freq_ff;
  assign remote_wr_refused = refused_ff;
  assign reg_rdata         = rdata_ff;
  assign sda_out           = 1'b0;
  assign sda_oe            = sda_oe_ff;
  assign bus_free          = wd_if.bus_free;
  assign wd_if.enable      = !ctrl_ff[WD_OFF_BIT]; // RL13
  assign wd_if.speedup     = ctrl_ff[WD_FAST_BIT]; // RL10

  mic_bus_wdog #(
    .SLOW_CYC (SLOW_CYC),
    .FAST_CYC (FAST_CYC),
    .HALF_CYC (RECOV_HALF_CYC)
  ) u_wdog (
    .clk     (clk),
    .rst_n   (rst_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .scl_out (scl_out),
    .scl_oe  (scl_oe),
    .cfg     (wd_if.wdog)
  );

  chk_mode_resv: assert property (@(posedge clk) disable iff (!rst_n) // RL15
    (mode_ff & ~MODE_WMASK) == 8'h00 && (ctrl_ff & ~CTRL_WMASK) == 8'h00)
    else $error("Reserved bit set.");
  chk_remote_block: assert property (@(posedge clk) disable iff (!rst_n) // RL8
    reg_wr_en && reg_wr_remote && ctrl_ff[RWR_BLOCK_BIT] |=> $stable(mode_ff) && $stable(ctrl_ff)
    && remote_wr_refused) else $error("Blocked remote write took effect.");
  chk_local_write: assert property (@(posedge clk) disable iff (!rst_n) // RL9
    reg_wr_en && !reg_wr_remote && reg_addr == MODE_ADDR |=> mode_ff == ($past(reg_wdata) & MODE_WMASK))
    else $error("Local write lost.");
  // The source check starts only once reset was already released, so the reset value is skipped.
  chk_legacy_src: assert property (@(posedge clk) disable iff (!rst_n) // RL3
    rst_n |=> legacy_pair_mode == ($past(mode_ff[LEG_OVR_BIT]) ? $past(mode_ff[LEG_MODE_BIT])
    : $past(legacy_strap_pin))) else $error("Wrong legacy mode source.");
  chk_freq_src: assert property (@(posedge clk) disable iff (!rst_n) // RL5
    rst_n |=> low_freq_range == ($past(mode_ff[FRQ_OVR_BIT]) ? $past(mode_ff[FRQ_MODE_BIT])
    : $past(freq_strap_pin))) else $error("Wrong frequency range source.");
  // The shortest delay: still low 29 cycles after the request is seen, high one cycle later.
  chk_sda_base: assert property (@(posedge clk) disable iff (!rst_n) // RL7
    $rose(sda_drive_req) && sda_code == 2'h0 |-> ##29 !sda_oe ##1 (sda_oe || sda_code != 2'h0))
    else $error("SDA delay not 240 ns.");
  chk_sda_max: assert property (@(posedge clk) disable iff (!rst_n) // RL7
    $rose(sda_drive_req) && sda_code == 2'h3 |-> ##44 !sda_oe ##1 (sda_oe || sda_code != 2'h3))
    else $error("SDA delay not 360 ns.");
  chk_crc_clear: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    wr_allowed && reg_addr == MODE_ADDR && reg_wdata[CRC_CLR_BIT] |=> crc_err_clear)
    else $error("CRC clear not asserted.");
  cov_refused: cover property (@(posedge clk) disable iff (!rst_n) remote_wr_refused);
  cov_legacy_reg: cover property (@(posedge clk) disable iff (!rst_n)
    mode_ff[LEG_OVR_BIT] && legacy_pair_mode);
endmodule
`default_nettype wire

// [testbench/mic_host_model.sv]
// Purpose: Far-side serial bus host with open-drain SCL and SDA lines.
// Assumes: Both lines have pull-ups; every party only pulls a line low.
// Notes:   The levels are worked out from the host's and the device's pull-downs.
`timescale 1ns/1ns
`default_nettype none
module mic_host_model (
  input  wire logic host_scl_low,
  input  wire logic host_sda_low,
  input  wire logic dev_scl_oe,
  input  wire logic dev_sda_oe,
  output logic      scl_line,
  output logic      sda_line
);
  // A released line floats up to the pull-up level.
  assign scl_line = ~(host_scl_low | dev_scl_oe);
  assign sda_line = ~(host_sda_low | dev_sda_oe);
endmodule
`default_nettype wire

// [testbench/mic_ctrl_regs_tb_top.sv]
// Purpose: Self-checking bench for the mode and serial-bus control registers.
// Assumes: Short watchdog limits; the bus lines are pulled up.
// Notes:   Inputs change on the rising edge by non-blocking assignment.
`timescale 1ns/1ns
`default_nettype none
module mic_ctrl_regs_tb_top;
  import mic_pkg::*;
  localparam int SLOW = 200;
  localparam int FAST = 50;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       reg_wr_en = 1'b0;
  logic       reg_rd_en = 1'b0;
  logic       reg_wr_remote = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       leg_pin = 1'b1;
  logic       frq_pin = 1'b1;
  logic       drv_req = 1'b0;
  logic       host_scl_low = 1'b0;
  logic       host_sda_low = 1'b0;
  logic       scl_in, sda_in, scl_oe, sda_oe, fs_low, crc_clr, leg, lfr, refused, bus_free;
  logic       scl_o, sda_o;
  logic       scl_oe_q = 1'b0;
  int         n_fail = 0;
  int         compares = 0;
  int         cyc = 0;
  int         n_ref = 0;
  int         n_free = 0;
  int         n_rise = 0;
  int         n, f;
  logic [7:0] mw [4] = '{8'h8f, 8'h0a, 8'h24, 8'hff};
  logic [7:0] mr [4] = '{8'h8f, 8'h0a, 8'h24, 8'haf};
  logic [3:0] mo [4] = '{4'hb, 4'h0, 4'h4, 4'hf};

  mic_ctrl_regs #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) dut (
    .clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wr_remote(reg_wr_remote), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .legacy_strap_pin(leg_pin), .freq_strap_pin(frq_pin),
    .sda_drive_req(drv_req), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_o),
    .scl_oe(scl_oe), .sda_out(sda_o), .sda_oe(sda_oe), .failsafe_low(fs_low),
    .crc_err_clear(crc_clr), .legacy_pair_mode(leg), .low_freq_range(lfr),
    .remote_wr_refused(refused), .bus_free(bus_free));
  mic_host_model host (.host_scl_low(host_scl_low), .host_sda_low(host_sda_low),
    .dev_scl_oe(scl_oe), .dev_sda_oe(sda_oe), .scl_line(scl_in), .sda_line(sda_in));

  // The clock toggles every half period.
  always #4 clk = ~clk;

  // Tallies of pulses and SCL pull-downs, plus the hang limit.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    scl_oe_q <= scl_oe;
    if (refused === 1'b1) n_ref <= n_ref + 1;
    if (bus_free === 1'b1) n_free <= n_free + 1;
    if (scl_oe === 1'b1 && scl_oe_q === 1'b0) n_rise <= n_rise + 1;
    if (cyc == 40000) begin
      n_fail++;
      complete_run();
    end
  end

  // Compares seen against expected and reports a difference.
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_ok(input string what, input logic ok);
    chk(what, {7'h00, ok}, 8'h01);
  endtask

  // One write strobe, held until the taking edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rem);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_remote <= rem;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_wr_remote <= 1'b0;
  endtask

  // One read strobe; the data is taken once the answering edge has landed.
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic sda_wait(input logic v, output int k);
    k = 0;
    while (sda_oe !== v && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  // Pulses SDA once as bus activity, then counts cycles to the free pulse.
  task automatic free_time(output int k);
    @(posedge clk);
    host_sda_low <= 1'b1;
    @(posedge clk);
    host_sda_low <= 1'b0;
    k = 0;
    f = n_free;
    while (n_free == f && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  task automatic complete_run();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence of register and bus scenarios.
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    chk_ok("straps and failsafe", leg === 1'b1 && lfr === 1'b1 && fs_low === 1'b1);
    chk_ok("open drain levels", scl_o === 1'b0 && sda_o === 1'b0);
    rchk("mode reset", MODE_ADDR, 8'h80);
    rchk("ctrl reset", CTRL_ADDR, 8'h00);
    @(posedge clk);
    leg_pin <= 1'b0;
    frq_pin <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(MODE_ADDR, mw[i], 1'b0);
      settle();
      chk("mode outputs", {4'h0, fs_low, crc_clr, leg, lfr}, {4'h0, mo[i]});
      rchk("mode readback", MODE_ADDR, mr[i]);
    end
    wr(CTRL_ADDR, 8'hff, 1'b0);
    rchk("ctrl readback", CTRL_ADDR, 8'h1f);
    rchk("unmapped read", 8'h07, 8'h00);
    f = n_ref;
    wr(MODE_ADDR, 8'h00, 1'b1);
    settle();
    chk_ok("refused pulse", n_ref == f + 1);
    rchk("mode kept", MODE_ADDR, 8'haf);
    wr(CTRL_ADDR, 8'h01, 1'b0);
    wr(MODE_ADDR, 8'h00, 1'b1);
    rchk("remote write", MODE_ADDR, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(CTRL_ADDR, 8'(c * 8 + 1), 1'b0);
      @(posedge clk);
      drv_req <= 1'b1;
      sda_wait(1'b1, n);
      chk_ok("sda delay rise", n >= 29 + 5 * c && n <= 31 + 5 * c);
      @(posedge clk);
      drv_req <= 1'b0;
      sda_wait(1'b0, n);
      chk_ok("sda delay fall", n >= 29 + 5 * c && n <= 31 + 5 * c);
      // Let the delay line drain so a longer tap cannot pick up the old request.
      repeat (SDA_LINE_DEPTH) @(posedge clk);
    end
    host_sda_low <= 1'b1;
    f = n_free;
    n = n_rise;
    repeat (300) @(posedge clk);
    chk_ok("watchdog off", n_free == f && n_rise == n);
    wr(CTRL_ADDR, 8'h02, 1'b0);
    n = n_rise;
    repeat (10300) @(posedge clk);
    // Release SDA during the ninth pulse; no tenth pulse may follow.
    host_sda_low <= 1'b0;
    repeat (700) @(posedge clk);
    chk_ok("nine scl pulses", n_rise == n + 9);
    wr(CTRL_ADDR, 8'h01, 1'b0);
    wr(CTRL_ADDR, 8'h02, 1'b0);
    free_time(n);
    chk_ok("fast timeout", n >= FAST - 3 && n <= FAST + 6);
    wr(CTRL_ADDR, 8'h00, 1'b0);
    free_time(n);
    chk_ok("slow timeout", n >= SLOW - 3 && n <= SLOW + 6);
    complete_run();
  end
endmodule
`default_nettype wire
